// [hw/pooc_on_off_ctrl.sv]
// On/off, margin and fault-handling command decoder for a converter
`timescale 1ns/1ns
//
// Function
// - Enable field 00 stops at once, 01 stops softly, 10 runs.
// - Margin field 00 nominal, 01 margin low, 10 margin high.
// - Margined: fault field 01 ignores faults, 10 acts on them.
// - Config bit 4 clear: run whenever input power is present.
// - Config bit 4 set: run only when pin and command both allow.
// - Config bit 3 clear: ignore the operation enable field.
// - Config bit 3 set: run only while enable field commands run.
// - Config bit 2 clear ignores pin; set requires pin asserted.
// - Config bit 1 selects pin polarity: 0 active low, 1 high.
// - Pin turn-off is soft if bit 0 clear, immediate if set.
// - Operation byte at code 01 is held and read back.
// - Configuration byte at code 02 is held and applied.
// - Write-protect 40 blocks writes except protect, operation, page.
module pooc_on_off_ctrl
    import pooc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic power_good_in,
    input wire logic ctrl_pin,
    input wire logic req_valid,
    input pooc_req_t req,
    output logic req_accept,
    output logic wr_reject,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output pooc_ctrl_t ctrl
);

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        POOC_ST_OFF = 3'b001,
        POOC_ST_RUN = 3'b010,
        POOC_ST_STOP = 3'b100
    } pooc_state_t;

    function automatic logic [1:0] code_idx(input logic [7:0] code);
        unique case (code)
            POOC_CMD_OPERATION: code_idx = 2'h1;
            POOC_CMD_ONOFF_CFG: code_idx = 2'h2;
            POOC_CMD_WRPROT: code_idx = 2'h3;
            default: code_idx = 2'h0;
        endcase
    endfunction : code_idx

    function automatic logic code_known(input logic [7:0] code);
        code_known = (code == POOC_CMD_OPERATION) ||
                     (code == POOC_CMD_ONOFF_CFG) ||
                     (code == POOC_CMD_WRPROT);
    endfunction : code_known

    logic [7:0] wp_q;
    logic [7:0] op_q;
    logic [7:0] cf_q;
    logic [31:0] all_q;
    logic wr_allowed;
    logic wr_go;
    logic [7:0] mem_rd;
    logic rd_pend_r;
    logic rd_known_r;

    assign op_q = all_q[15:8];
    assign cf_q = all_q[23:16];
    assign wp_q = all_q[31:24];

    // Control level also keeps the configuration byte writable
    always_comb begin
        wr_allowed = 1'b1;
        if (req.code == POOC_CMD_WRPROT) begin
            wr_allowed = 1'b1;
        end else if (wp_q == POOC_WP_ALL) begin
            wr_allowed = 1'b0;
        end else if (wp_q == POOC_WP_OPER) begin
            wr_allowed = (req.code == POOC_CMD_OPERATION) ||
                         (req.code == POOC_CMD_PAGE);
        end else if (wp_q == POOC_WP_CTRL) begin
            wr_allowed = (req.code == POOC_CMD_OPERATION) ||
                         (req.code == POOC_CMD_PAGE) ||
                         (req.code == POOC_CMD_ONOFF_CFG);
        end
    end

    assign req_accept = 1'b1;
    assign wr_go = req_valid && req.write && wr_allowed &&
                   code_known(req.code);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reject <= 1'b0;
        end else begin
            wr_reject <= req_valid && req.write && !wr_allowed;
        end
    end

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    pooc_regfile #(
        .DEPTH(POOC_NUM_REGS)
    ) u_regs (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .wr_en(wr_go),
        .wr_idx(code_idx(req.code)),
        .wr_data(req.data),
        .rd_idx(code_idx(req.code)),
        .rd_data(mem_rd),
        .all_q(all_q)
    );

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_r <= 1'b0;
            rd_known_r <= 1'b0;
        end else begin
            rd_pend_r <= req_valid && !req.write;
            rd_known_r <= code_known(req.code);
        end
    end

    // Unknown codes read as zero rather than stale data
    assign rd_data = rd_known_r ? mem_rd : 8'h00;
    assign rd_valid = rd_pend_r;

    // ------------------------------------------------------------
    // Start conditions
    // ------------------------------------------------------------
    logic [1:0] en_f;
    logic [1:0] mg_f;
    logic [1:0] fa_f;
    logic pin_asserted;
    logic bus_ok;
    logic pin_ok;
    logic run_req;
    logic bus_imm;

    assign en_f = op_q[POOC_OP_EN_HI:POOC_OP_EN_LO];
    assign mg_f = op_q[POOC_OP_MG_HI:POOC_OP_MG_LO];
    assign fa_f = op_q[POOC_OP_FA_HI:POOC_OP_FA_LO];

    assign pin_asserted = cf_q[POOC_CF_POL] ? ctrl_pin : !ctrl_pin;
    assign pin_ok = !cf_q[POOC_CF_PINEN] || pin_asserted;
    assign bus_ok = !cf_q[POOC_CF_BUSEN] || (en_f == POOC_EN_ON);

    always_comb begin
        if (!power_good_in) begin
            run_req = 1'b0;
        end else if (!cf_q[POOC_CF_PWRUP]) begin
            run_req = 1'b1;
        end else begin
            run_req = bus_ok && pin_ok;
        end
    end

    // Bus-caused stop is immediate only for enable code 00
    assign bus_imm = cf_q[POOC_CF_PWRUP] && cf_q[POOC_CF_BUSEN] &&
                     (en_f == POOC_EN_IMM_OFF);

    // ------------------------------------------------------------
    // Run state machine
    // ------------------------------------------------------------
    pooc_state_t state_r;
    pooc_state_t state_nxt;
    logic imm_stop_r;
    logic imm_nxt;

    always_comb begin
        state_nxt = state_r;
        imm_nxt = imm_stop_r;
        unique case (state_r)
            POOC_ST_OFF: begin
                imm_nxt = 1'b0;
                if (run_req) begin
                    state_nxt = POOC_ST_RUN;
                end
            end
            POOC_ST_RUN: begin
                if (!run_req) begin
                    state_nxt = POOC_ST_STOP;
                    if (!power_good_in || bus_imm) begin
                        imm_nxt = 1'b1;
                    end else if (!pin_ok) begin
                        imm_nxt = cf_q[POOC_CF_IMMOFF];
                    end else begin
                        imm_nxt = 1'b0;
                    end
                end
            end
            POOC_ST_STOP: begin
                // Power stage owns ramp timing; one cycle marks the stop
                state_nxt = run_req ? POOC_ST_RUN : POOC_ST_OFF;
            end
            default: begin
                state_nxt = POOC_ST_OFF;
                imm_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= POOC_ST_OFF;
            imm_stop_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            imm_stop_r <= imm_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    pooc_target_t tgt;

    always_comb begin
        unique case (mg_f)
            POOC_MG_LOW: tgt = POOC_TGT_LOW;
            POOC_MG_HIGH: tgt = POOC_TGT_HIGH;
            default: tgt = POOC_TGT_NOM;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= '0;
        end else begin
            ctrl.run <= (state_nxt == POOC_ST_RUN);
            ctrl.soft_stop <= (state_nxt == POOC_ST_STOP) && !imm_nxt;
            ctrl.imm_stop <= (state_nxt == POOC_ST_STOP) && imm_nxt;
            ctrl.target <= tgt;
            ctrl.margined <= (tgt != POOC_TGT_NOM);
            ctrl.fault_ignore <= (tgt != POOC_TGT_NOM) &&
                                 (fa_f == POOC_FA_IGNORE);
        end
    end

endmodule : pooc_on_off_ctrl

// [hw/pooc_pkg.sv]
// Package: constants and types for the PMBus on/off control block
package pooc_pkg;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] POOC_CMD_OPERATION = 8'h01;
    localparam logic [7:0] POOC_CMD_ONOFF_CFG = 8'h02;
    localparam logic [7:0] POOC_CMD_WRPROT = 8'h10;
    localparam logic [7:0] POOC_CMD_PAGE = 8'h00;
    localparam int POOC_NUM_REGS = 4;

    // ------------------------------------------------------------
    // Write-protect settings
    // ------------------------------------------------------------
    localparam logic [7:0] POOC_WP_ALL = 8'h80;
    localparam logic [7:0] POOC_WP_OPER = 8'h40;
    localparam logic [7:0] POOC_WP_CTRL = 8'h20;
    localparam logic [7:0] POOC_WP_NONE = 8'h00;

    // ------------------------------------------------------------
    // Operation byte fields
    // ------------------------------------------------------------
    localparam int POOC_OP_EN_HI = 7;
    localparam int POOC_OP_EN_LO = 6;
    localparam int POOC_OP_MG_HI = 5;
    localparam int POOC_OP_MG_LO = 4;
    localparam int POOC_OP_FA_HI = 3;
    localparam int POOC_OP_FA_LO = 2;
    localparam logic [1:0] POOC_EN_IMM_OFF = 2'h0;
    localparam logic [1:0] POOC_EN_SOFT_OFF = 2'h1;
    localparam logic [1:0] POOC_EN_ON = 2'h2;
    localparam logic [1:0] POOC_MG_NOM = 2'h0;
    localparam logic [1:0] POOC_MG_LOW = 2'h1;
    localparam logic [1:0] POOC_MG_HIGH = 2'h2;
    localparam logic [1:0] POOC_FA_IGNORE = 2'h1;
    localparam logic [1:0] POOC_FA_ACT = 2'h2;

    // ------------------------------------------------------------
    // On/off configuration fields
    // ------------------------------------------------------------
    localparam int POOC_CF_PWRUP = 4;
    localparam int POOC_CF_BUSEN = 3;
    localparam int POOC_CF_PINEN = 2;
    localparam int POOC_CF_POL = 1;
    localparam int POOC_CF_IMMOFF = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] POOC_OP_RST = 8'h00;
    localparam logic [7:0] POOC_CF_RST = 8'h00;
    localparam logic [7:0] POOC_WP_RST = 8'h00;

    typedef enum logic [1:0] {
        POOC_TGT_NOM = 2'h0,
        POOC_TGT_LOW = 2'h1,
        POOC_TGT_HIGH = 2'h2
    } pooc_target_t;

    typedef struct packed {
        logic write;
        logic [7:0] code;
        logic [7:0] data;
    } pooc_req_t;

    typedef struct packed {
        logic run;
        logic soft_stop;
        logic imm_stop;
        pooc_target_t target;
        logic margined;
        logic fault_ignore;
    } pooc_ctrl_t;

endpackage : pooc_pkg

// [hw/pooc_regfile.sv]
// Small register memory holding the command byte values
`timescale 1ns/1ns
module pooc_regfile
    import pooc_pkg::*;
#(
    parameter int DEPTH = POOC_NUM_REGS
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input wire logic [7:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic [7:0] rd_data,
    output logic [DEPTH*8-1:0] all_q
);

    logic [7:0] mem_r [DEPTH];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= 8'h00;
            end
        end else if (wr_en) begin
            mem_r[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else if (wr_en && wr_idx == rd_idx) begin
            rd_data <= wr_data;
        end else begin
            rd_data <= mem_r[rd_idx];
        end
    end

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            all_q[i*8 +: 8] = mem_r[i];
        end
    end

endmodule : pooc_regfile

// [tb/pooc_props.sv]
// Port checks for the on/off control block
`timescale 1ns/1ns
module pooc_props
    import pooc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic power_good_in,
    input wire logic ctrl_pin,
    input wire logic req_valid,
    input wire pooc_req_t req,
    input wire logic req_accept,
    input wire logic wr_reject,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire pooc_ctrl_t ctrl
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Last protect level written; protect writes are never refused
    logic [7:0] wp_seen_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_seen_r <= POOC_WP_RST;
        end else if (req_valid && req.write &&
                     req.code == POOC_CMD_WRPROT) begin
            wp_seen_r <= req.data;
        end
    end
    sequence s_op_write;
        req_valid && req.write && req.code == POOC_CMD_OPERATION &&
            wp_seen_r != POOC_WP_ALL;
    endsequence
    sequence s_read;
        req_valid && !req.write;
    endsequence
    sequence s_stop;
        $fell(ctrl.run);
    endsequence
    a_read_answer: assert property (s_read |=> rd_valid)
        else $error("read not answered");
    a_read_cause: assert property (rd_valid |->
        $past(req_valid && !req.write))
        else $error("stray read answer");
    a_reject_cause: assert property (wr_reject |-> $past(req_valid))
        else $error("reject without write");
    a_op_allowed: assert property (s_op_write |=> !wr_reject)
        else $error("operation write refused");
    a_target_follow: assert property (s_op_write ##0
        req.data[POOC_OP_MG_HI:POOC_OP_MG_LO] != 2'h3 |=> ##1
        ctrl.target == $past(req.data[POOC_OP_MG_HI:POOC_OP_MG_LO], 2))
        else $error("target not taken");
    a_stop_kind: assert property (s_stop |->
        ctrl.soft_stop ^ ctrl.imm_stop)
        else $error("stop without one kind");
    a_stop_pulse: assert property (ctrl.soft_stop || ctrl.imm_stop
        |=> !(ctrl.soft_stop || ctrl.imm_stop))
        else $error("stop pulse too long");
    a_power_imm: assert property (!power_good_in && ctrl.run
        |=> !ctrl.run && ctrl.imm_stop)
        else $error("power loss not immediate");
    a_margin_flag: assert property (
        ctrl.margined == (ctrl.target != POOC_TGT_NOM))
        else $error("margined flag wrong");
    a_fault_gate: assert property (ctrl.fault_ignore |-> ctrl.margined)
        else $error("ignore while nominal");
endmodule : pooc_props

// [tb/pooc_host_model.sv]
// Host model issuing single byte commands
`timescale 1ns/1ns
module pooc_host_model
    import pooc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic wr_reject,
    output logic req_valid,
    output pooc_req_t req
);
    initial begin
        req_valid = 1'b0;
        req = '0;
    end
    // One-cycle request; released fields inverted, never left stale
    task automatic xfer(input logic w, input logic [7:0] c,
        input logic [7:0] d, output logic [7:0] q, output logic f);
        @(posedge ref_clk) #1;
        req_valid = 1'b1;
        req = '{write: w, code: c, data: d};
        @(posedge ref_clk) #1;
        q = rd_data;
        f = w ? wr_reject : rd_valid;
        req_valid = 1'b0;
        req = ~req;
    endtask : xfer
endmodule : pooc_host_model

// [tb/tb_top.sv]
// Self-checking bench for the on/off control block
`timescale 1ns/1ns
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin \
    fail_count++; $display("wrong value %0t %s", $time, m); end end
module tb_top
    import pooc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic power_good_in = 1'b1;
    logic ctrl_pin = 1'b0;
    logic req_valid, req_accept, wr_reject, rd_valid, f;
    logic [7:0] rd_data, q;
    pooc_req_t req;
    pooc_ctrl_t ctrl;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    always #20 ref_clk = ~ref_clk;
    pooc_on_off_ctrl pooc_on_off_ctrl_inst (.ref_clk(ref_clk),
        .rst_n(rst_n), .power_good_in(power_good_in), .ctrl_pin(ctrl_pin),
        .req_valid(req_valid), .req(req), .req_accept(req_accept),
        .wr_reject(wr_reject), .rd_data(rd_data), .rd_valid(rd_valid),
        .ctrl(ctrl));
    pooc_host_model pooc_host_model_inst (.ref_clk(ref_clk),
        .rd_valid(rd_valid), .rd_data(rd_data), .wr_reject(wr_reject),
        .req_valid(req_valid), .req(req));
    // ----
    // Scenario tasks
    // ----
    task automatic tick;
        @(posedge ref_clk) #1;
    endtask : tick
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        pooc_host_model_inst.xfer(1'b1, c, d, q, f);
    endtask : wr
    task automatic rd(input logic [7:0] c);
        pooc_host_model_inst.xfer(1'b0, c, 8'h00, q, f);
    endtask : rd
    task automatic t_reset;
        rd(POOC_CMD_OPERATION);
        `CHK(q, POOC_OP_RST, "op reset")
        rd(POOC_CMD_ONOFF_CFG);
        `CHK(q, POOC_CF_RST, "cfg reset")
        `CHK(ctrl.run, 1'b1, "always on")
        rd(8'h7F);
        `CHK(q, 8'h00, "unmapped")
        `CHK(f, 1'b1, "read answered")
        `CHK(req_accept, 1'b1, "accept")
    endtask : t_reset
    task automatic t_bus;
        wr(POOC_CMD_ONOFF_CFG, 8'h18);
        tick;
        `CHK(ctrl.imm_stop, 1'b1, "bus imm off")
        for (int i = 0; i < 3; i++) begin
            wr(POOC_CMD_OPERATION, {POOC_EN_ON, 2'(i), POOC_FA_IGNORE, 2'h0});
            tick;
            `CHK(ctrl.run, 1'b1, "bus on")
            `CHK(ctrl.target, 2'(i), "target")
            `CHK(ctrl.fault_ignore, i != 0, "ignore")
            `CHK(ctrl.margined, i != 0, "margined")
        end
        wr(POOC_CMD_OPERATION, 8'hA8);
        tick;
        `CHK(ctrl.fault_ignore, 1'b0, "act")
        wr(POOC_CMD_OPERATION, 8'h40);
        tick;
        `CHK(ctrl.soft_stop, 1'b1, "soft off")
    endtask : t_bus
    task automatic t_pin;
        wr(POOC_CMD_OPERATION, 8'h00);
        for (int i = 0; i < 4; i++) begin
            ctrl_pin = i[0];
            wr(POOC_CMD_ONOFF_CFG, {6'h05, i[1], 1'b0});
            tick;
            `CHK(ctrl.run, i[0] == i[1], "pin")
        end
        wr(POOC_CMD_ONOFF_CFG, 8'h17);
        tick;
        ctrl_pin = 1'b0;
        tick;
        `CHK(ctrl.imm_stop, 1'b1, "pin imm")
        ctrl_pin = 1'b1;
        wr(POOC_CMD_ONOFF_CFG, 8'h16);
        tick;
        ctrl_pin = 1'b0;
        tick;
        `CHK(ctrl.soft_stop, 1'b1, "pin soft")
        wr(POOC_CMD_OPERATION, 8'h80);
        wr(POOC_CMD_ONOFF_CFG, 8'h1E);
        tick;
        `CHK(ctrl.run, 1'b0, "pin blocks")
        ctrl_pin = 1'b1;
        tick;
        `CHK(ctrl.run, 1'b1, "both allow")
    endtask : t_pin
    task automatic t_prot;
        wr(POOC_CMD_ONOFF_CFG, 8'h10);
        wr(POOC_CMD_WRPROT, POOC_WP_OPER);
        wr(POOC_CMD_ONOFF_CFG, 8'h00);
        `CHK(f, 1'b1, "cfg blocked")
        rd(POOC_CMD_ONOFF_CFG);
        `CHK(q, 8'h10, "cfg kept")
        wr(POOC_CMD_OPERATION, 8'h44);
        `CHK(f, 1'b0, "op allowed")
        wr(POOC_CMD_PAGE, 8'h00);
        `CHK(f, 1'b0, "page allowed")
        rd(POOC_CMD_OPERATION);
        `CHK(q, 8'h44, "op back")
        wr(POOC_CMD_WRPROT, POOC_WP_CTRL);
        `CHK(f, 1'b0, "wp ctrl")
        wr(POOC_CMD_ONOFF_CFG, 8'h00);
        `CHK(f, 1'b0, "cfg under ctrl")
        rd(POOC_CMD_ONOFF_CFG);
        `CHK(q, 8'h00, "cfg taken")
        wr(POOC_CMD_WRPROT, POOC_WP_ALL);
        `CHK(f, 1'b0, "wp all")
        wr(POOC_CMD_OPERATION, 8'h80);
        `CHK(f, 1'b1, "op blocked")
        rd(POOC_CMD_OPERATION);
        `CHK(q, 8'h44, "op kept")
        wr(POOC_CMD_WRPROT, POOC_WP_NONE);
        `CHK(f, 1'b0, "wp allowed")
        wr(8'h7F, 8'h55);
        `CHK(f, 1'b0, "unknown silent")
        rd(8'h7F);
        `CHK(q, 8'h00, "unknown not kept")
        power_good_in = 1'b0;
        tick;
        `CHK(ctrl.imm_stop, 1'b1, "power loss")
        power_good_in = 1'b1;
        tick;
        `CHK(ctrl.run, 1'b1, "power back")
        rst_n = 1'b0;
        tick;
        `CHK(ctrl.run, 1'b0, "reset stops")
        rst_n = 1'b1;
        rd(POOC_CMD_OPERATION);
        `CHK(q, POOC_OP_RST, "op cleared")
        `CHK(ctrl.run, 1'b1, "runs again")
    endtask : t_prot
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    // Ceiling well above the roughly 110 cycles the run needs
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            conclude;
        end
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        t_reset;
        t_bus;
        t_pin;
        t_prot;
        conclude;
    end
endmodule : tb_top
bind pooc_on_off_ctrl pooc_props pooc_props_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .power_good_in(power_good_in), .ctrl_pin(ctrl_pin),
    .req_valid(req_valid), .req(req), .req_accept(req_accept),
    .wr_reject(wr_reject), .rd_data(rd_data), .rd_valid(rd_valid),
    .ctrl(ctrl));
